// file: rtl/spierr_pkg.sv
// package of constants and carrier types for the spi error flag block
package spierr_pkg;

  // ==========================================================
  // reset values and synchroniser depth
  localparam logic RST_FLAG = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // cpu-side register strobes, one cycle each
  typedef struct packed {
    logic csr_rd;     // read of ctrl_status_reg
    logic csr_wr;     // write of ctrl_status_reg
    logic cr_wr;      // write of control_reg
    logic dr_rd;      // read of data_reg
    logic dr_wr;      // write of data_reg
    logic [7:0] wdata; // data for data_reg writes
  } spierr_cpu_type;

  // ==========================================================
  // control bits written by software into control_reg
  typedef struct packed {
    logic irq_enable_bit;
    logic port_enable_bit;
    logic master_select_bit;
  } spierr_ctrl_type;

  // ==========================================================
  // status flags as seen in ctrl_status_reg
  typedef struct packed {
    logic transfer_done_flag;
    logic write_collision_flag;
    logic overrun_flag;
    logic mode_fault_flag;
  } spierr_stat_type;

  // ==========================================================
  // flag clearing sequence states
  typedef enum logic [0:0] {
    SEQ_IDLE = 1'b0,
    SEQ_ARMED = 1'b1
  } spierr_seq_type;

endpackage : spierr_pkg

// file: rtl/spierr_link.sv
// link-clock side: byte completion and busy indication on the link clock
`timescale 1ns/1ns
module spierr_link (
  input wire logic link_clock,
  input wire logic rst,
  input wire logic frame_active, // transfer in progress, link domain
  input wire logic byte_done,    // one-cycle pulse, byte shifted
  input wire logic [7:0] byte_in,
  output logic done_toggle_q,    // flips once per finished byte
  output logic [7:0] byte_q,     // byte held stable across the toggle
  output logic busy_q            // transfer in progress, a level
);
  import spierr_pkg::*;

  // ==========================================================
  // capture a finished byte and signal it by a toggle
  // a toggle crosses safely even though this clock stops between frames
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      done_toggle_q <= RST_FLAG;
      byte_q <= RST_BYTE;
    end else if (byte_done) begin
      done_toggle_q <= ~done_toggle_q;
      byte_q <= byte_in;
    end
  end

  // ==========================================================
  // busy level, registered before leaving the domain
  always_ff @(posedge link_clock or posedge rst) begin
    if (rst) begin
      busy_q <= RST_FLAG;
    end else begin
      busy_q <= frame_active & ~byte_done;
    end
  end

endmodule : spierr_link

// file: rtl/spierr_top.sv
// error flag, clearing sequence and low-power logic of the spi port
// Overview of operation
// - master with select low means mode fault
// - mode fault sets flag, interrupt if enabled
// - mode fault clears port enable bit
// - mode fault clears master select bit
// - mode fault clears: status read, control write
// - enable/master writes can only clear them while fault flagged, except the clearing write
// - fault never set in slave operation
// - byte completing with done flag set overruns
// - overrun sets flag, interrupt if enabled
// - buffer keeps first byte, later bytes dropped; of bytes in halt the last is kept
// - status register read clears overrun flag
// - data write during transfer is discarded
// - collision flag set in master or slave
// - collision flag raises no interrupt
// - receive buffer read synchronously, never collides
// - wait mode unchanged, enabled events wake
// - halt freezes registers, resumes on wake
// - several bytes in halt give overrun
// - done flag clears: status access, data access
`timescale 1ns/1ns
module spierr_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clock,           // serial clock domain
  input wire logic frame_active,         // link domain
  input wire logic byte_done,            // link domain pulse
  input wire logic [7:0] byte_in,        // link domain
  input wire logic slave_select_n,       // pin, asynchronous
  input wire logic halt_mode,            // cpu in halt, same clock
  input wire logic wait_mode,            // cpu in wait, same clock
  input wire spierr_pkg::spierr_cpu_type cpu,
  input wire spierr_pkg::spierr_ctrl_type ctrl_wdata,
  output spierr_pkg::spierr_ctrl_type ctrl_q,
  output spierr_pkg::spierr_stat_type stat_q,
  output logic [7:0] rx_data_q,          // receive buffer
  output logic [7:0] tx_data_q,          // accepted transmit byte
  output logic tx_load,                  // pulse: byte accepted
  output logic irq,                      // interrupt request
  output logic wake                      // wake request from wait
);
  import spierr_pkg::*;

  // ==========================================================
  // link domain instance
  logic done_toggle;
  logic [7:0] link_byte;
  logic link_busy;

  spierr_link u_link (
    .link_clock(link_clock),
    .rst(rst),
    .frame_active(frame_active),
    .byte_done(byte_done),
    .byte_in(byte_in),
    .done_toggle_q(done_toggle),
    .byte_q(link_byte),
    .busy_q(link_busy)
  );

  // ==========================================================
  // synchronisers: first stage is read only by the second
  logic [SYNC_STAGES-1:0] ss_sync_q;   // slave select pin
  logic [SYNC_STAGES-1:0] busy_sync_q; // transfer in progress
  logic [SYNC_STAGES-1:0] tog_sync_q;  // byte completion toggle
  logic tog_seen_q;                    // second stage, one clock later

  // two-flop chains for each level crossing into the cpu clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ss_sync_q <= '1;                 // deselected after reset
      busy_sync_q <= '0;
      tog_sync_q <= '0;
    end else begin
      ss_sync_q <= {ss_sync_q[0], slave_select_n};
      busy_sync_q <= {busy_sync_q[0], link_busy};
      tog_sync_q <= {tog_sync_q[0], done_toggle};
    end
  end

  // the completion edge is taken from the second stage only
  // in halt the edge is held back and replayed once on wake, since
  // two toggles seen in halt would cancel out in a parity compare
  // limitation: bytes seen in halt leave only the last in the buffer
  logic byte_evt;
  logic tog_edge;                      // one finished byte, cpu clock
  logic ss_low;
  logic busy;
  logic halt_first_q;                  // a byte finished in halt
  logic halt_pending_q;                // more than one byte in halt
  assign tog_edge = tog_sync_q[1] != tog_seen_q;
  assign byte_evt = (tog_edge | halt_first_q) & ~halt_mode;
  assign ss_low = ~ss_sync_q[1];
  assign busy = busy_sync_q[1];

  // ==========================================================
  // completion edge bookkeeping
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tog_seen_q <= RST_FLAG;
    end else begin
      // runs in halt as well, so each byte is seen exactly once
      tog_seen_q <= tog_sync_q[1];
    end
  end

  // count bytes that finished while halted; a second one overruns
  // both are cleared on wake, in the cycle the replayed event fires
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      halt_first_q <= RST_FLAG;
      halt_pending_q <= RST_FLAG;
    end else if (halt_mode) begin
      // every edge of the delayed second stage is one new byte
      if (tog_edge) begin
        halt_first_q <= 1'b1;
        halt_pending_q <= halt_first_q | halt_pending_q;
      end
    end else begin
      halt_first_q <= RST_FLAG;
      halt_pending_q <= RST_FLAG;
    end
  end

  // ==========================================================
  // clearing sequence state, one per flag except overrun
  spierr_seq_type mode_fault_flag_seq_q;          // status read with fault set
  spierr_seq_type transfer_done_flag_seq_q;          // status access with done set
  spierr_seq_type write_collision_flag_seq_q;          // status read seen

  // decoded events
  logic mode_fault_evt;
  logic mode_fault_flag_clear;
  logic transfer_done_flag_clear;
  logic write_collision_flag_clear;
  logic csr_access;
  logic dr_access;
  logic collide;

  assign csr_access = cpu.csr_rd | cpu.csr_wr;
  assign dr_access = cpu.dr_rd | cpu.dr_wr;
  // fault only in master operation, never as slave
  assign mode_fault_evt = ctrl_q.master_select_bit & ss_low
                          & ~halt_mode;
  // clears are strobes too, so halt holds them off like the rest
  assign mode_fault_flag_clear = (mode_fault_flag_seq_q == SEQ_ARMED) & cpu.cr_wr
                      & ~halt_mode;
  assign transfer_done_flag_clear = (transfer_done_flag_seq_q == SEQ_ARMED) & dr_access
                      & ~halt_mode;
  assign write_collision_flag_clear = (write_collision_flag_seq_q == SEQ_ARMED) & dr_access
                      & ~halt_mode;
  // a data write while shifting, or while done is still pending
  assign collide = cpu.dr_wr & (busy | stat_q.transfer_done_flag);

  // arm the mode fault sequence on a status read while flagged
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_fault_flag_seq_q <= SEQ_IDLE;
    end else if (halt_mode) begin
      mode_fault_flag_seq_q <= mode_fault_flag_seq_q;
    end else if (cpu.cr_wr) begin
      mode_fault_flag_seq_q <= SEQ_IDLE;
    end else if (cpu.csr_rd && stat_q.mode_fault_flag) begin
      mode_fault_flag_seq_q <= SEQ_ARMED;
    end
  end

  // arm the done sequence on any status access while done is set
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      transfer_done_flag_seq_q <= SEQ_IDLE;
    end else if (halt_mode) begin
      transfer_done_flag_seq_q <= transfer_done_flag_seq_q;
    end else if (dr_access) begin
      transfer_done_flag_seq_q <= SEQ_IDLE;
    end else if (csr_access && stat_q.transfer_done_flag) begin
      transfer_done_flag_seq_q <= SEQ_ARMED;
    end
  end

  // arm the collision sequence on a status read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_collision_flag_seq_q <= SEQ_IDLE;
    end else if (halt_mode) begin
      write_collision_flag_seq_q <= write_collision_flag_seq_q;
    end else if (dr_access) begin
      write_collision_flag_seq_q <= SEQ_IDLE;
    end else if (cpu.csr_rd) begin
      write_collision_flag_seq_q <= SEQ_ARMED;
    end
  end

  // ==========================================================
  // control bits: software writes, hardware clears on a fault
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q <= '0;
    end else if (halt_mode) begin
      ctrl_q <= ctrl_q;
    end else if (mode_fault_evt) begin
      // fault wins over a simultaneous write
      ctrl_q.port_enable_bit <= 1'b0;
      ctrl_q.master_select_bit <= 1'b0;
      if (cpu.cr_wr) begin
        ctrl_q.irq_enable_bit <= ctrl_wdata.irq_enable_bit;
      end
    end else if (cpu.cr_wr) begin
      ctrl_q.irq_enable_bit <= ctrl_wdata.irq_enable_bit;
      if (stat_q.mode_fault_flag && !mode_fault_flag_clear) begin
        // only clears get through while the fault stands
        ctrl_q.port_enable_bit <= ctrl_q.port_enable_bit
                                  & ctrl_wdata.port_enable_bit;
        ctrl_q.master_select_bit <= ctrl_q.master_select_bit
                                    & ctrl_wdata.master_select_bit;
      end else begin
        ctrl_q.port_enable_bit <= ctrl_wdata.port_enable_bit;
        ctrl_q.master_select_bit <= ctrl_wdata.master_select_bit;
      end
    end
  end

  // ==========================================================
  // mode fault flag: set wins over the clearing write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q.mode_fault_flag <= RST_FLAG;
    end else if (mode_fault_evt) begin
      stat_q.mode_fault_flag <= 1'b1;
    end else if (mode_fault_flag_clear) begin
      stat_q.mode_fault_flag <= 1'b0;
    end
  end

  // transfer done flag: set by a finished byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q.transfer_done_flag <= RST_FLAG;
    end else if (byte_evt) begin
      stat_q.transfer_done_flag <= 1'b1;
    end else if (transfer_done_flag_clear) begin
      stat_q.transfer_done_flag <= 1'b0;
    end
  end

  // overrun: byte finished with done still pending, or several in halt
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q.overrun_flag <= RST_FLAG;
    end else if (byte_evt && (stat_q.transfer_done_flag
                              || halt_pending_q)) begin
      stat_q.overrun_flag <= 1'b1;
    end else if (cpu.csr_rd && !halt_mode) begin
      stat_q.overrun_flag <= 1'b0;
    end
  end

  // write collision: status only, master or slave alike
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_q.write_collision_flag <= RST_FLAG;
    end else if (collide && !halt_mode) begin
      stat_q.write_collision_flag <= 1'b1;
    end else if (write_collision_flag_clear) begin
      stat_q.write_collision_flag <= 1'b0;
    end
  end

  // ==========================================================
  // receive buffer: loads only when done is clear, so the first
  // byte after a clear survives an overrun; cpu reads it directly
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_data_q <= RST_BYTE;
    end else if (byte_evt && !stat_q.transfer_done_flag) begin
      rx_data_q <= link_byte;
    end
  end

  // ==========================================================
  // transmit byte: writes during a transfer are dropped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_data_q <= RST_BYTE;
    end else if (cpu.dr_wr && !collide && !halt_mode) begin
      tx_data_q <= cpu.wdata;
    end
  end

  // accepted write pulse towards the shifter
  assign tx_load = cpu.dr_wr & ~collide & ~halt_mode;

  // ==========================================================
  // interrupt and wake: collision takes no part in either
  logic event_pending;
  assign event_pending = stat_q.transfer_done_flag | stat_q.overrun_flag
                         | stat_q.mode_fault_flag;
  assign irq = ctrl_q.irq_enable_bit & event_pending;
  // wait leaves operation untouched; any enabled event wakes
  assign wake = wait_mode & irq;

endmodule : spierr_top

// file: tb/spierr_monitor.sv
// checker of the spi error flag block, bound to the top module
`timescale 1ns/1ns
module spierr_monitor
  import spierr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic slave_select_n,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire spierr_pkg::spierr_cpu_type cpu,
  input wire spierr_pkg::spierr_ctrl_type ctrl_q,
  input wire spierr_pkg::spierr_stat_type stat_q,
  input wire logic [7:0] tx_data_q,
  input wire logic tx_load,
  input wire logic irq,
  input wire logic wake
);
  // ==========================================================
  // one domain: cpu clock, reset disables everything
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // select low in master mode: synchroniser delay bounds the wait
  property p_fault_det;
    ctrl_q.master_select_bit && !slave_select_n && !halt_mode
      |-> ##[1:5] stat_q.mode_fault_flag;
  endproperty
  a_fault_det: assert property (p_fault_det)
    else $error("fault not flagged");
  property p_fault_off;
    $rose(stat_q.mode_fault_flag)
      |-> !ctrl_q.port_enable_bit && !ctrl_q.master_select_bit;
  endproperty
  a_fault_off: assert property (p_fault_off)
    else $error("enable or master kept on fault");
  property p_fault_master;
    $rose(stat_q.mode_fault_flag) |-> $past(ctrl_q.master_select_bit);
  endproperty
  a_fault_master: assert property (p_fault_master)
    else $error("fault set in slave operation");
  property p_fault_clr;
    $fell(stat_q.mode_fault_flag) |-> $past(cpu.cr_wr);
  endproperty
  a_fault_clr: assert property (p_fault_clr)
    else $error("fault cleared without control write");
  property p_no_set;
    $rose(ctrl_q.port_enable_bit) || $rose(ctrl_q.master_select_bit)
      |-> !stat_q.mode_fault_flag;
  endproperty
  a_no_set: assert property (p_no_set)
    else $error("enable set while fault flagged");
  // collision flag is excluded from the request on purpose
  property p_irq_map;
    irq == (ctrl_q.irq_enable_bit && (stat_q.transfer_done_flag
      || stat_q.overrun_flag || stat_q.mode_fault_flag));
  endproperty
  a_irq_map: assert property (p_irq_map)
    else $error("interrupt request wrong");
  property p_ovr_clr;
    cpu.csr_rd && !halt_mode && stat_q.overrun_flag
      |=> !stat_q.overrun_flag;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr)
    else $error("overrun not cleared by status read");
  property p_write_collision_flag;
    cpu.dr_wr && !halt_mode && stat_q.transfer_done_flag
      |-> !tx_load ##1 stat_q.write_collision_flag;
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag)
    else $error("inhibited write accepted");
  property p_done_clr;
    $fell(stat_q.transfer_done_flag) |-> $past(cpu.dr_rd || cpu.dr_wr);
  endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("done cleared without data access");
  property p_write_collision_flag_clr;
    $fell(stat_q.write_collision_flag)
      |-> $past(cpu.dr_rd || cpu.dr_wr);
  endproperty
  a_write_collision_flag_clr: assert property (p_write_collision_flag_clr)
    else $error("collision cleared without data access");
  property p_halt;
    halt_mode |=> $stable(stat_q) && $stable(ctrl_q);
  endproperty
  a_halt: assert property (p_halt)
    else $error("registers moved in halt");
  property p_wake;
    wait_mode && irq |-> wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake from wait");
  property p_tx;
    tx_load |=> tx_data_q == $past(cpu.wdata);
  endproperty
  a_tx: assert property (p_tx)
    else $error("accepted byte lost");
  // main scenarios reached
  c_fault: cover property ($rose(stat_q.mode_fault_flag));
  c_ovr: cover property ($rose(stat_q.overrun_flag));
  c_write_collision_flag: cover property ($rose(stat_q.write_collision_flag));
endmodule : spierr_monitor

bind spierr_top spierr_monitor spierr_monitor_inst (.clock, .rst,
  .slave_select_n, .halt_mode, .wait_mode, .cpu, .ctrl_q, .stat_q,
  .tx_data_q, .tx_load, .irq, .wake);

// file: tb/spierr_peer.sv
// far-side link model: serial clock and finished bytes
`timescale 1ns/1ns
module spierr_peer (
  output logic link_clock,
  output logic frame_active,
  output logic byte_done,
  output logic [7:0] byte_in
);
  // ==========================================================
  // idle: clock stands still between frames
  initial begin
    link_clock = 1'b0;
    frame_active = 1'b0;
    byte_done = 1'b0;
    byte_in = 8'hFF;
  end
  // one frame of eight link clocks plus one to drop the pulse;
  // data line shows the inverse outside the capture edge
  task send(input logic [7:0] b);
    frame_active <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      #24 link_clock = 1'b1;
      byte_done <= (i == 7);
      byte_in <= (i == 7) ? b : ~b;
      #24 link_clock = 1'b0;
    end
    frame_active <= 1'b0;
  endtask : send
endmodule : spierr_peer

// file: tb/tb_spi_error_flags.sv
// self-checking bench of the spi error flag block
`timescale 1ns/1ns
module tb_spi_error_flags;
  import spierr_pkg::*;
  // ==========================================================
  // strobe codes: csr_rd csr_wr cr_wr dr_rd dr_wr
  localparam logic [4:0] CSR_RD = 5'h10;
  localparam logic [4:0] CSR_WR = 5'h08;
  localparam logic [4:0] CR_WR = 5'h04;
  localparam logic [4:0] DR_RD = 5'h02;
  localparam logic [4:0] DR_WR = 5'h01;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic link_clock, frame_active, byte_done, tx_load, irq, wake;
  logic [7:0] byte_in, rx_data_q, tx_data_q;
  logic slave_select_n; // pulled high while idle
  logic halt_mode;
  logic wait_mode;
  spierr_cpu_type cpu;
  spierr_ctrl_type ctrl_wdata;
  spierr_ctrl_type ctrl_q;
  spierr_stat_type stat_q;
  int n_fail = 0;
  int checks = 0;
  always #5 clock = ~clock;
  spierr_top spierr_top_inst (.clock, .rst, .link_clock, .frame_active,
    .byte_done, .byte_in, .slave_select_n, .halt_mode, .wait_mode, .cpu,
    .ctrl_wdata, .ctrl_q, .stat_q, .rx_data_q, .tx_data_q, .tx_load,
    .irq, .wake);
  spierr_peer spierr_peer_inst (.link_clock, .frame_active, .byte_done,
    .byte_in);
  // ==========================================================
  // helpers
  task chk(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // one strobe cycle; #1 lets the edge's updates land before checks
  task op(input logic [4:0] s, input logic [7:0] d, input logic [2:0] c);
    @(posedge clock) begin
      cpu <= {s, d};
      ctrl_wdata <= c;
    end
    @(posedge clock) cpu <= '0;
    #1;
  endtask : op
  task wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wt
  // ==========================================================
  // scenarios
  task t_fault;
    op(CR_WR, 8'h00, 3'b111);
    @(posedge clock) slave_select_n <= 1'b0;
    wt(6);
    chk("stat", 8'h01, {4'h0, stat_q});
    chk("ctrl", 8'h04, {5'h0, ctrl_q});
    chk("irq", 8'h01, {7'h0, irq});
    op(CR_WR, 8'h00, 3'b111);
    chk("ctrl", 8'h04, {5'h0, ctrl_q});
    @(posedge clock) slave_select_n <= 1'b1;
    wt(4);
    op(CSR_RD, 8'h00, 3'b000);
    op(CR_WR, 8'h00, 3'b110);
    chk("stat", 8'h00, {4'h0, stat_q});
    chk("ctrl", 8'h06, {5'h0, ctrl_q});
    @(posedge clock) slave_select_n <= 1'b0;
    wt(6);
    chk("stat", 8'h00, {4'h0, stat_q});
    @(posedge clock) slave_select_n <= 1'b1;
    wt(4);
    $display("t_fault finished");
  endtask : t_fault
  task t_ovr;
    spierr_peer_inst.send(8'hA5);
    wt(6);
    chk("irq", 8'h01, {7'h0, irq});
    spierr_peer_inst.send(8'h3C);
    spierr_peer_inst.send(8'h96);
    wt(6);
    chk("stat", 8'h0A, {4'h0, stat_q});
    chk("rx", 8'hA5, rx_data_q);
    op(DR_WR, 8'h44, 3'b110);
    chk("stat", 8'h0E, {4'h0, stat_q});
    chk("tx", 8'h00, tx_data_q);
    op(CSR_RD, 8'h00, 3'b110);
    chk("stat", 8'h0C, {4'h0, stat_q});
    op(DR_RD, 8'h00, 3'b110);
    chk("stat", 8'h00, {4'h0, stat_q});
    $display("t_ovr finished");
  endtask : t_ovr
  task t_write_collision_flag;
    fork
      spierr_peer_inst.send(8'h5A);
      begin
        wt(20);
        op(DR_WR, 8'hC3, 3'b110);
        chk("stat", 8'h04, {4'h0, stat_q});
        chk("irq", 8'h00, {7'h0, irq});
      end
    join
    wt(6);
    chk("rx", 8'h5A, rx_data_q);
    chk("tx", 8'h00, tx_data_q);
    op(CSR_RD, 8'h00, 3'b110);
    op(DR_RD, 8'h00, 3'b110);
    chk("stat", 8'h00, {4'h0, stat_q});
    chk("rx", 8'h5A, rx_data_q);
    op(DR_WR, 8'h77, 3'b110);
    chk("tx", 8'h77, tx_data_q);
    wt(60);
    $display("t_write_collision_flag finished");
  endtask : t_write_collision_flag
  task t_low;
    op(CSR_RD, 8'h00, 3'b110);
    op(DR_RD, 8'h00, 3'b110);
    @(posedge clock) wait_mode <= 1'b1;
    spierr_peer_inst.send(8'h11);
    wt(6);
    chk("wake", 8'h01, {7'h0, wake});
    op(CSR_WR, 8'h00, 3'b110);
    op(DR_RD, 8'h00, 3'b110);
    @(posedge clock) begin
      wait_mode <= 1'b0;
      halt_mode <= 1'b1;
    end
    spierr_peer_inst.send(8'h22);
    spierr_peer_inst.send(8'h33);
    wt(6);
    chk("stat", 8'h00, {4'h0, stat_q});
    @(posedge clock) halt_mode <= 1'b0;
    wt(8);
    chk("stat", 8'h0A, {4'h0, stat_q});
    $display("t_low finished");
  endtask : t_low
  // ==========================================================
  // verdict, the single exit of the run
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict
  // watchdog: the tests need about 5 us
  initial begin
    #100000;
    n_fail++;
    print_verdict;
  end
  initial begin
    slave_select_n <= 1'b1;
    halt_mode <= 1'b0;
    wait_mode <= 1'b0;
    cpu <= '0;
    ctrl_wdata <= '0;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    t_fault;
    t_ovr;
    t_write_collision_flag;
    t_low;
    print_verdict;
  end
endmodule : tb_spi_error_flags
